// ---- include/tmr_defines.svh ----
// Purpose: Register indices, field masks and reset values of the timers
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_IDX_CTR0_HIGH   6'h0c
`define TMR_IDX_CTR0_LOW    6'h0d
`define TMR_IDX_CTR0_CTRL   6'h0e
`define TMR_IDX_CTR1_HIGH   6'h0f
`define TMR_IDX_CTR1_LOW    6'h10
`define TMR_IDX_CTR1_CTRL   6'h11
`define TMR_IDX_CTR2_VALUE  6'h2c
`define TMR_IDX_CTR2_CTRL   6'h2e
`define TMR_IDX_IRQ_STATUS  6'h30
`define TMR_IDX_IRQ_MASK    6'h31

`define TMR_CTRL02_MASK     8'hdf
`define TMR_CTRL1_MASK      8'hf8
`define TMR_CTRL_RESET      8'h00
`define TMR_MAX_WIDE        16'hffff
`define TMR_MAX_NARROW      16'h00ff
`define TMR_DIV4_LAST       2'h3
`define TMR_RESP_OKAY       2'h0
`define TMR_RESP_SLVERR     2'h2

`endif

// ---- include/tmr_pkg.sv ----
// Purpose: Types shared by the timer/event counter block
// Assumes: Constants live in tmr_defines.svh
// Notes:   Control byte layout is bit 7 down to bit 0
package tmr_pkg;

	typedef enum logic [1:0] {
		MODE_UNUSED = 2'b00,
		MODE_EVENT  = 2'b01,
		MODE_TIMER  = 2'b10,
		MODE_PULSE  = 2'b11
	} ctr_mode_e;

	typedef struct packed {
		ctr_mode_e  mode;
		logic       src_sel;
		logic       run;
		logic       edge_sel;
		logic [2:0] prescale;
	} ctr_ctrl_s;

	typedef enum logic {
		PW_ARMED   = 1'b0,
		PW_MEASURE = 1'b1
	} pulse_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic       lane0;
	} reg_wr_s;

endpackage : tmr_pkg

// ---- hw/timer_event_counter_control.sv ----
// Purpose: Three timer/event counters with AXI4-Lite register access
// Assumes: Event and oscillator inputs are asynchronous to clock
// Notes:   Unused control bits are neither stored nor returned
// Operation
// RULE1: Counter 0 internal clock is system clock over two to the select.
// RULE2: Counter 2 uses the same power-of-two prescaler from its low bits.
// RULE3: Event mode counts falling edges when edge bit is 1, else rising.
// RULE4: Pulse mode edge bit 1 measures high level, 0 measures low level.
// RULE5: Top control bits pick mode: 01 event, 10 timer, 11 pulse.
// RULE6: A counter counts only while its run bit 4 is set.
// RULE7: Unused control bits read back as zero.
// RULE8: Counter 1 internal source is clock/4 or the 32768Hz oscillator.
// RULE9: Counters overflow at all ones, reload preload and raise a flag.
// RULE10: Pulse mode clears run after one measurement and keeps the result.
// RULE11: Wide low byte write goes to a buffer; high write commits both.
// RULE12: Preload write also loads a stopped counter; running waits reload.
// RULE13: Counter 1 mode bits sit at positions 6 and 7.
// RULE14: Mode 00 never counts, even with run set.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tmr_defines.svh"

module timer_event_counter_control (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Pins
	input  wire logic        ctr0_event_input,
	input  wire logic        ctr1_event_input,
	input  wire logic        ctr2_event_input,
	input  wire logic        rtc_osc,
	// Interrupt
	output logic             irq
);

	localparam int NCH = 3;

	// Write and read path holding registers
	logic                aw_hold_q;
	logic [7:0]          awaddr_q;
	logic                w_hold_q;
	logic [7:0]          wdata_q;
	logic                wlane_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	tmr_pkg::reg_wr_s    wr;
	logic                do_wr;
	logic                wr_hit;
	logic                rd_take;
	logic [5:0]          rd_idx;
	logic                rd_hit;
	logic [7:0]          rd_byte;

	// Register state
	tmr_pkg::ctr_ctrl_s  ctl_q [NCH];
	logic [15:0]         cnt_q [NCH];
	logic [15:0]         pre_q [NCH];
	logic [7:0]          low_buf_q [2];
	logic [2:0]          irq_st_q;
	logic [2:0]          irq_mask_q;
	logic [NCH-1:0]      wr_ctl;
	logic [NCH-1:0]      wr_pre;
	logic [NCH-1:0]      rd_high;
	logic [1:0]          wr_low;
	logic                wr_st;
	logic                wr_mask;
	logic [15:0]         pre_new [NCH];
	logic [NCH-1:0]      ovf;
	logic [NCH-1:0]      pw_stop;

	// Pin synchronisers: three event inputs and the oscillator
	logic [2:0]          sync_q [4];
	logic [3:0]          lvl_q;
	logic [3:0]          lvl_prev_q;
	logic [3:0]          rise;
	logic [3:0]          fall;

	// Internal clock sources
	logic [6:0]          psc_q;
	logic [1:0]          div4_q;

	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready  = !w_hold_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign wr      = '{addr: awaddr_q, data: wdata_q, lane0: wlane_q};
	assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q;
	assign rd_take = s_axi_arvalid && !rvalid_q;
	assign rd_idx  = s_axi_araddr[7:2];

	// Address and data are taken in either order, then the write happens
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= 8'h00;
		end else if (s_axi_awvalid && !aw_hold_q) begin
			aw_hold_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			w_hold_q <= 1'b0;
			wdata_q  <= 8'h00;
			wlane_q  <= 1'b0;
		end else if (s_axi_wvalid && !w_hold_q) begin
			w_hold_q <= 1'b1;
			wdata_q  <= s_axi_wdata[7:0];
			wlane_q  <= s_axi_wstrb[0];
		end else if (do_wr) begin
			w_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `TMR_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Write decode; only byte lane 0 carries register data
	always_comb begin
		wr_ctl  = '0;
		wr_pre  = '0;
		wr_low  = '0;
		wr_st   = 1'b0;
		wr_mask = 1'b0;
		wr_hit  = 1'b1;
		if (wr.addr[1:0] != 2'h0) begin
			wr_hit = 1'b0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR0_HIGH) begin
			wr_pre[0] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR0_LOW) begin
			wr_low[0] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR0_CTRL) begin
			wr_ctl[0] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR1_HIGH) begin
			wr_pre[1] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR1_LOW) begin
			wr_low[1] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR1_CTRL) begin
			wr_ctl[1] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR2_VALUE) begin
			wr_pre[2] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_CTR2_CTRL) begin
			wr_ctl[2] = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_IRQ_STATUS) begin
			wr_st = do_wr && wr.lane0;
		end else if (wr.addr[7:2] == `TMR_IDX_IRQ_MASK) begin
			wr_mask = do_wr && wr.lane0;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// Wide counters commit the buffered low byte with the high byte
	assign pre_new[0] = {wr.data, low_buf_q[0]}; // [RULE11]
	assign pre_new[1] = {wr.data, low_buf_q[1]}; // [RULE11]
	assign pre_new[2] = {8'h00, wr.data};

	// Read decode; reading a high byte snapshots the low byte
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		rd_high = '0;
		if (s_axi_araddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (rd_idx == `TMR_IDX_CTR0_HIGH) begin
			rd_byte    = cnt_q[0][15:8];
			rd_high[0] = rd_take;
		end else if (rd_idx == `TMR_IDX_CTR0_LOW) begin
			rd_byte = low_buf_q[0];
		end else if (rd_idx == `TMR_IDX_CTR0_CTRL) begin
			rd_byte = ctl_q[0] & `TMR_CTRL02_MASK; // [RULE7]
		end else if (rd_idx == `TMR_IDX_CTR1_HIGH) begin
			rd_byte    = cnt_q[1][15:8];
			rd_high[1] = rd_take;
		end else if (rd_idx == `TMR_IDX_CTR1_LOW) begin
			rd_byte = low_buf_q[1];
		end else if (rd_idx == `TMR_IDX_CTR1_CTRL) begin
			rd_byte = ctl_q[1] & `TMR_CTRL1_MASK; // [RULE7]
		end else if (rd_idx == `TMR_IDX_CTR2_VALUE) begin
			rd_byte = cnt_q[2][7:0];
		end else if (rd_idx == `TMR_IDX_CTR2_CTRL) begin
			rd_byte = ctl_q[2] & `TMR_CTRL02_MASK; // [RULE7]
		end else if (rd_idx == `TMR_IDX_IRQ_STATUS) begin
			rd_byte = {5'h00, irq_st_q};
		end else if (rd_idx == `TMR_IDX_IRQ_MASK) begin
			rd_byte = {5'h00, irq_mask_q};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `TMR_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rresp_q  <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Low byte buffer shared by low writes and high-byte reads
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_buf_q[0] <= 8'h00;
			low_buf_q[1] <= 8'h00;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (wr_low[k]) begin
					low_buf_q[k] <= wr.data; // [RULE11]
				end else if (rd_high[k]) begin
					low_buf_q[k] <= cnt_q[k][7:0];
				end
			end
		end
	end

	// Sticky flags: an overflow in the clearing cycle wins over the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_st_q <= 3'h0;
		end else begin
			irq_st_q <= (irq_st_q & ~(wr_st ? wr.data[2:0] : 3'h0)) | ovf;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q <= 3'h0;
		end else if (wr_mask) begin
			irq_mask_q <= wr.data[2:0];
		end
	end

	assign irq = |(irq_st_q & irq_mask_q);

	// Three flops per pin; a level counts once stages two and three agree
	for (genvar j = 0; j < 4; j++) begin : g_sync
		logic pin;
		assign pin = (j == 0) ? ctr0_event_input :
		             (j == 1) ? ctr1_event_input :
		             (j == 2) ? ctr2_event_input : rtc_osc;
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				sync_q[j]     <= 3'h0;
				lvl_q[j]      <= 1'b0;
				lvl_prev_q[j] <= 1'b0;
			end else begin
				sync_q[j]     <= {sync_q[j][1:0], pin};
				lvl_prev_q[j] <= lvl_q[j];
				if (sync_q[j][1] == sync_q[j][2]) begin
					lvl_q[j] <= sync_q[j][2];
				end
			end
		end
		assign rise[j] = lvl_q[j] && !lvl_prev_q[j];
		assign fall[j] = !lvl_q[j] && lvl_prev_q[j];
	end

	// Free-running prescaler and divide-by-four source
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			psc_q  <= 7'h00;
			div4_q <= 2'h0;
		end else begin
			psc_q  <= psc_q + 7'h01;
			div4_q <= div4_q + 2'h1;
		end
	end

	// Per-counter engine
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		localparam logic [15:0] MAX =
			(i == 2) ? `TMR_MAX_NARROW : `TMR_MAX_WIDE;
		tmr_pkg::ctr_ctrl_s     ctl;
		tmr_pkg::pulse_state_e  pw_q;
		logic [7:0]             msk;
		logic                   tick;
		logic                   ev_edge;
		logic                   start_edge;
		logic                   stop_edge;
		logic                   inc;

		assign ctl = ctl_q[i];
		// A tick every 2^select cycles; select 0 ticks every cycle
		assign msk = (8'h01 << ctl.prescale) - 8'h01;
		if (i == 1) begin : g_src
			assign tick = ctl.src_sel ? rise[3] : // [RULE8]
			              (div4_q == `TMR_DIV4_LAST); // [RULE8]
		end else begin : g_psc
			assign tick = ((psc_q & msk[6:0]) == msk[6:0]); // [RULE1] [RULE2]
		end

		assign ev_edge    = ctl.edge_sel ? fall[i] : rise[i]; // [RULE3]
		assign start_edge = ctl.edge_sel ? rise[i] : fall[i]; // [RULE4]
		assign stop_edge  = ctl.edge_sel ? fall[i] : rise[i]; // [RULE4]

		always_comb begin
			case (ctl.mode) // [RULE5] [RULE13]
				tmr_pkg::MODE_EVENT: inc = ctl.run && ev_edge; // [RULE6]
				tmr_pkg::MODE_TIMER: inc = ctl.run && tick; // [RULE6]
				tmr_pkg::MODE_PULSE:
					inc = ctl.run && tick && (pw_q == tmr_pkg::PW_MEASURE);
				default: inc = 1'b0; // [RULE14]
			endcase
		end

		assign ovf[i]     = inc && (cnt_q[i] == MAX); // [RULE9]
		assign pw_stop[i] = ctl.run && (ctl.mode == tmr_pkg::MODE_PULSE) &&
		                    (pw_q == tmr_pkg::PW_MEASURE) && stop_edge;

		// Waits armed for the start edge, single shot until run is set again
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				pw_q <= tmr_pkg::PW_ARMED;
			end else if (!ctl.run || ctl.mode != tmr_pkg::MODE_PULSE) begin
				pw_q <= tmr_pkg::PW_ARMED;
			end else begin
				case (pw_q)
					tmr_pkg::PW_ARMED: begin
						if (start_edge) begin
							pw_q <= tmr_pkg::PW_MEASURE; // [RULE4]
						end
					end
					default: begin
						if (stop_edge) begin
							pw_q <= tmr_pkg::PW_ARMED;
						end
					end
				endcase
			end
		end

		// A software write in the same cycle wins over the auto-clear
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				ctl_q[i] <= `TMR_CTRL_RESET;
			end else if (wr_ctl[i]) begin
				ctl_q[i] <= wr.data &
					((i == 1) ? `TMR_CTRL1_MASK : `TMR_CTRL02_MASK); // [RULE7]
			end else if (pw_stop[i]) begin
				ctl_q[i].run <= 1'b0; // [RULE10]
			end
		end

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				pre_q[i] <= 16'h0000;
			end else if (wr_pre[i]) begin
				pre_q[i] <= pre_new[i]; // [RULE11]
			end
		end

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q[i] <= 16'h0000;
			end else if (wr_pre[i] && !ctl.run) begin
				cnt_q[i] <= pre_new[i]; // [RULE12]
			end else if (ovf[i]) begin
				cnt_q[i] <= pre_q[i]; // [RULE9] [RULE12]
			end else if (inc) begin
				cnt_q[i] <= cnt_q[i] + 16'h0001; // [RULE9]
			end
		end
	end

endmodule : timer_event_counter_control

// ---- verif/tmr_event_source.sv ----
// Purpose: Far-side model driving the event pins and the slow oscillator
// Assumes: Pins are plain levels with no pull
// Notes:   Oscillator runs free, half period 610 clocks
`timescale 1ns/100ps

module tmr_event_source (
	// Clock
	input  wire logic       clock,
	// Pins
	output logic [2:0]      event_pin,
	output logic            osc
);
	int osc_cnt;

	initial begin
		event_pin = 3'h0;
		osc = 1'b0;
		osc_cnt = 0;
	end

	// Free-running crystal, so no stop between uses
	always @(posedge clock) begin
		osc_cnt <= (osc_cnt == 609) ? 0 : osc_cnt + 1;
		if (osc_cnt == 609) osc <= !osc;
	end

	// Slow or prompt edges come from the hold count
	task automatic drive(input int c, input logic v, input int hold);
		@(posedge clock);
		event_pin[c] <= v;
		repeat (hold) @(posedge clock);
	endtask : drive
endmodule : tmr_event_source

// ---- verif/tmr_chk_asserts.sv ----
// Purpose: Bus handshake and control readback checks
// Assumes: Address and data of a write are offered together
// Notes:   Bound to the top module
`timescale 1ns/100ps
`include "tmr_defines.svh"

module tmr_chk (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	logic [5:0] ar_idx_q;
	logic [7:0] c1_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n) ar_idx_q <= 6'h00;
		else if (s_axi_arvalid && s_axi_arready) ar_idx_q <= s_axi_araddr[7:2];

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// Shadow of the last counter 1 control write, for mode readback
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n) c1_q <= 8'h00;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == {`TMR_IDX_CTR1_CTRL, 2'b00}) c1_q <= s_axi_wdata[7:0];

	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	chk_misalign_err: assert property (s_wr_taken ##0 (!s_axi_bvalid
		&& s_axi_awaddr[1:0] != 2'b00) |=> ##1 s_axi_bvalid
		&& s_axi_bresp == `TMR_RESP_SLVERR) else $error("misaligned ok");
	chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_ctrl0_unused: assert property (s_axi_rvalid && ar_idx_q ==
		`TMR_IDX_CTR0_CTRL |-> !s_axi_rdata[5]) else $error("ctrl0 bit5 set");
	chk_ctrl2_unused: assert property (s_axi_rvalid && ar_idx_q ==
		`TMR_IDX_CTR2_CTRL |-> !s_axi_rdata[5]) else $error("ctrl2 bit5 set");
	chk_ctrl1_unused: assert property (s_axi_rvalid && ar_idx_q ==
		`TMR_IDX_CTR1_CTRL |-> s_axi_rdata[2:0] == 3'h0) else $error("ctrl1 low");
	chk_ctrl1_mode: assert property (s_axi_rvalid && ar_idx_q ==
		`TMR_IDX_CTR1_CTRL |-> s_axi_rdata[7:5] == c1_q[7:5])
		else $error("ctrl1 mode bits");
endmodule : tmr_chk

bind timer_event_counter_control tmr_chk u_chk (.clock(clock), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata));

// ---- verif/timer_event_counter_control_tb.sv ----
// Purpose: Self-checking bench for the timer block
// Assumes: Pin edges reach the counters within 12 clocks
// Notes:   Free-running prescalers give a one-period slack on tick counts
`timescale 1ns/100ps
`include "tmr_defines.svh"

module timer_event_counter_control_tb;
	typedef struct {logic [5:0] idx; logic [7:0] wd, rd; logic [1:0] rs;} row_s;
	logic clock, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq, osc;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, d;
	logic [1:0] bresp, r, rrs, rdr;
	logic [2:0] pin;
	logic [15:0] v, w;
	int err_total, n_compared, cyc;
	localparam logic [5:0] ctl_idx [3] = '{`TMR_IDX_CTR0_CTRL,
		`TMR_IDX_CTR1_CTRL, `TMR_IDX_CTR2_CTRL};
	localparam logic [5:0] hi_idx [3] = '{`TMR_IDX_CTR0_HIGH,
		`TMR_IDX_CTR1_HIGH, `TMR_IDX_CTR2_VALUE};
	localparam logic [5:0] lo_idx [3] = '{`TMR_IDX_CTR0_LOW,
		`TMR_IDX_CTR1_LOW, 6'h3f};
	row_s rows [6] = '{'{`TMR_IDX_CTR0_CTRL, 8'hef, 8'hcf, 2'h0},
		'{`TMR_IDX_CTR1_CTRL, 8'hef, 8'he8, 2'h0},
		'{`TMR_IDX_CTR2_CTRL, 8'hef, 8'hcf, 2'h0},
		'{`TMR_IDX_IRQ_MASK, 8'h07, 8'h07, 2'h0},
		'{6'h3f, 8'hff, 8'h00, 2'h2},
		'{`TMR_IDX_CTR0_CTRL, 8'h00, 8'h00, 2'h0}};

	timer_event_counter_control uut (.clock(clock), .rst_n(rst_n),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
		.s_axi_rresp(rrs),
		.ctr0_event_input(pin[0]), .ctr1_event_input(pin[1]),
		.ctr2_event_input(pin[2]), .rtc_osc(osc), .irq(irq));
	tmr_event_source u_src (.clock(clock), .event_pin(pin), .osc(osc));

	function automatic logic [7:0] a(input logic [5:0] i);
		return {i, 2'b00};
	endfunction : a

	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic bus_wr(input logic [7:0] ad, dt, output logic [1:0] rs);
		@(posedge clock);
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		awa <= ad;
		wd <= {24'h0, dt};
		do begin
			@(posedge clock);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wrd));
		while (!bv) @(posedge clock);
		rs = bresp;
		br <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge clock);
		arv <= 1'b1;
		ara <= ad;
		rr <= 1'b1;
		do @(posedge clock); while (!arr);
		arv <= 1'b0;
		do @(posedge clock); while (!rv);
		dt = rd;
		rdr = rrs;
		rr <= 1'b0;
	endtask : bus_rd

	task automatic load(input int c, input logic [15:0] x);
		if (c != 2) bus_wr(a(lo_idx[c]), x[7:0], r);
		bus_wr(a(hi_idx[c]), (c == 2) ? x[7:0] : x[15:8], r);
	endtask : load

	task automatic read_ctr(input int c, output logic [15:0] x);
		bus_rd(a(hi_idx[c]), d);
		x = {8'h0, d[7:0]};
		if (c != 2) begin
			bus_rd(a(lo_idx[c]), d);
			x = {x[7:0], d[7:0]};
		end
	endtask : read_ctr

	// lo above hi means no overflow is expected within hi cycles
	task automatic run_timer(input int c, input logic [7:0] ctl, input int lo, hi);
		int n;
		bus_wr(a(ctl_idx[c]), 8'h00, r);
		load(c, 16'hfff0);
		bus_wr(a(`TMR_IDX_IRQ_STATUS), 8'h07, r);
		bus_wr(a(ctl_idx[c]), ctl, r);
		n = 0;
		while (irq !== 1'b1 && n <= hi) begin
			@(posedge clock);
			n++;
		end
		check("ticks", 32'(n >= lo && (n <= hi || lo > hi)), 32'h1);
		bus_wr(a(ctl_idx[c]), 8'h00, r);
	endtask : run_timer

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Whole run is near 29000 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			end_of_test();
		end
	end

	initial begin
		{rst_n, awv, wv, br, arv, rr, awa, ara, wd} = '0;
		{err_total, n_compared, cyc} = '0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			bus_wr(a(rows[i].idx), rows[i].wd, r);
			check("bresp", 32'(r), 32'(rows[i].rs));
			bus_rd(a(rows[i].idx), d);
			check("rresp", 32'(rdr), 32'(rows[i].rs));
			check("ctl", d, 32'(rows[i].rd));
		end
		$display("end table");
		for (int p = 0; p < 8; p++) begin
			run_timer(0, 8'h90 | 8'(p), (15 << p) - 2, (16 << p) + 8);
			run_timer(2, 8'h90 | 8'(p), (15 << p) - 2, (16 << p) + 8);
		end
		run_timer(1, 8'h90, 58, 72);
		run_timer(1, 8'hb0, 15 * 1220, 16 * 1222 + 8);
		run_timer(0, 8'h10, 301, 300);
		run_timer(0, 8'h82, 301, 300);
		$display("end timer");
		for (int c = 0; c < 3; c++) for (int e = 0; e < 2; e++) begin
			w = (c == 2) ? 16'h00fe : 16'hfffe;
			bus_wr(a(ctl_idx[c]), 8'h00, r);
			load(c, 16'hfffe);
			bus_wr(a(`TMR_IDX_IRQ_STATUS), 8'h07, r);
			bus_wr(a(ctl_idx[c]), 8'h50 | 8'(e << 3), r);
			u_src.drive(c, 1'b1, 12);
			read_ctr(c, v);
			check("rise", 32'(v), 32'(w + 16'(1 - e)));
			u_src.drive(c, 1'b0, 12);
			read_ctr(c, v);
			check("fall", 32'(v), 32'(w + 16'h1));
			u_src.drive(c, 1'b1, 12);
			u_src.drive(c, 1'b0, 12);
			read_ctr(c, v);
			check("reload", 32'(v), 32'(w));
			bus_rd(a(`TMR_IDX_IRQ_STATUS), d);
			check("status", d, 32'(1 << c));
		end
		bus_wr(a(`TMR_IDX_IRQ_MASK), 8'h00, r);
		check("irq", 32'(irq), 32'h0);
		bus_wr(a(`TMR_IDX_IRQ_MASK), 8'h07, r);
		check("irq", 32'(irq), 32'h1);
		bus_wr(a(`TMR_IDX_IRQ_STATUS), 8'h04, r);
		check("irq", 32'(irq), 32'h0);
		$display("end event");
		for (int e = 0; e < 2; e++) begin
			bus_wr(a(ctl_idx[2]), 8'h00, r);
			load(2, 16'h0000);
			u_src.drive(2, !e, 12);
			bus_wr(a(ctl_idx[2]), 8'hd0 | 8'(e << 3), r);
			u_src.drive(2, e, 40);
			u_src.drive(2, !e, 12);
			read_ctr(2, v);
			check("width", 32'(v >= 38 && v <= 43), 32'h1);
			bus_rd(a(ctl_idx[2]), d);
			check("run", d, 32'(8'hc0 | 8'(e << 3)));
			u_src.drive(2, e, 20);
			u_src.drive(2, !e, 12);
			read_ctr(2, w);
			check("keep", 32'(w), 32'(v));
		end
		$display("end pulse");
		// Low byte alone must not reach a running wide counter
		bus_wr(a(lo_idx[0]), 8'h56, r);
		read_ctr(0, v);
		check("buffer", 32'(v), 32'hfffe);
		bus_wr(a(ctl_idx[2]), 8'h00, r);
		load(2, 16'h00ff);
		bus_wr(a(ctl_idx[2]), 8'h50, r);
		load(2, 16'h0010);
		read_ctr(2, v);
		check("held", 32'(v), 32'h00ff);
		u_src.drive(2, 1'b1, 12);
		read_ctr(2, v);
		check("preload", 32'(v), 32'h0010);
		check("irq", 32'(irq), 32'h1);
		$display("end preload");
		bus_wr(8'h39, 8'h0f, r);
		check("bresp", 32'(r), 32'h2);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		check("irq", 32'(irq), 32'h0);
		rst_n <= 1'b1;
		bus_rd(a(`TMR_IDX_IRQ_MASK), d);
		check("mask", d, 32'h0);
		$display("end reset");
		end_of_test();
	end
endmodule : timer_event_counter_control_tb
